// File: common/acsl_regs.svh
// Register offsets, field positions and reset values of the switch
// extended-capability register bank.
// Assumes inclusion by both design files; definitions only.
`ifndef ACSL_REGS_SVH
`define ACSL_REGS_SVH

// =============================================================
// Address layout of the APB window.
// =============================================================
`define ACSL_ADDR_W        14        // APB address width in bits.
`define ACSL_PORT_MSB      13        // Upper bit of the port select.
`define ACSL_PORT_LSB      12        // Lower bit of the port select.
`define ACSL_OFF_MSB       11        // Upper bit of the config offset.
`define ACSL_PORT_UP       2'h0      // Upstream port number.
`define ACSL_PORT_DN1      2'h1      // First downstream port number.
`define ACSL_PORT_DN2      2'h2      // Second downstream port number.

// =============================================================
// Register offsets inside one port's configuration space.
// =============================================================
`define ACSL_OFF_ACS_HDR   12'h220   // Access control header.
`define ACSL_OFF_ACS_CAP   12'h224   // Capability and control word.
`define ACSL_OFF_EGRESS    12'h228   // Peer egress block vector.
`define ACSL_OFF_LTR_HDR   12'h230   // Latency reporting header.
`define ACSL_OFF_SNOOP     12'h234   // Maximum snoop latency.

// =============================================================
// Fixed header fields.
// =============================================================
`define ACSL_ACS_CAP_ID    16'h000d  // Access control capability id.
`define ACSL_LTR_CAP_ID    16'h0018  // Latency reporting capability id.
`define ACSL_CAP_VER       4'h1      // Capability version.
`define ACSL_NEXT_PTR      12'h240   // Next capability pointer.

// =============================================================
// Capability word and egress vector fields.
// =============================================================
`define ACSL_FEAT_W        7         // Number of feature bits.
`define ACSL_FEAT_SUPPORT  7'h7f     // All seven features supported.
`define ACSL_ENA_LSB       16        // Lowest enable bit position.
`define ACSL_ENA_MSB       22        // Highest enable bit position.
`define ACSL_ENA_RESET     7'h00     // Enables reset cleared.
`define ACSL_EGR_SIZE      8'h08     // Meaningful egress vector bits.
`define ACSL_EGR_W         8         // Egress vector width.
`define ACSL_EGR_RESET     8'h00     // Egress vector reset value.

// =============================================================
// Maximum snoop latency fields.
// =============================================================
`define ACSL_LAT_VAL_MSB   9         // Latency value upper bit.
`define ACSL_LAT_SCL_LSB   10        // Latency scale lower bit.
`define ACSL_LAT_SCL_MSB   12        // Latency scale upper bit.
`define ACSL_LAT_VAL_RESET 10'h000   // Latency value reset value.
`define ACSL_LAT_SCL_RESET 3'h0      // Latency scale reset value.

`endif

// File: common/acsl_pkg.sv
// Types shared by the extended-capability register bank.
// Assumes the offsets and fields live in acsl_regs.svh.
package acsl_pkg;

    // =========================================================
    // APB answer sequencer states.
    // =========================================================
    typedef enum logic [0:0] {
        ACSL_IDLE,
        ACSL_ANSWER
    } acsl_apb_state_t;

endpackage

// File: hw/acsl_dn_port_regs.sv
// One downstream port's access control register set.
// Assumes the parent decodes the port and hands over a held offset.
`timescale 1ns/10ps
`include "acsl_regs.svh"

module acsl_dn_port_regs
    import acsl_pkg::*;
(
    input  wire logic                        clk_in,        // Core clock.
    input  wire logic                        rst_n_in,      // Synchronous reset, active low.
    input  wire logic                        wr_in,         // One-cycle write commit.
    input  wire logic [`ACSL_OFF_MSB:0]      off_in,        // Register offset.
    input  wire logic [31:0]                 wdata_in,      // Write data.
    output logic      [31:0]                 rdata_out,     // Read data for the offset.
    output logic                             hit_out,       // Offset is mapped here.
    output logic      [`ACSL_FEAT_W-1:0]     ena_out,       // Feature enables.
    output logic      [`ACSL_EGR_W-1:0]      egress_out     // Egress block vector.
);

    // =========================================================
    // State.
    // =========================================================
    logic [`ACSL_FEAT_W-1:0] ena_r;       // Feature enable flops.
    logic [`ACSL_FEAT_W-1:0] ena_nxt;     // Next enables.
    logic [`ACSL_EGR_W-1:0]  egress_r;    // Egress vector flops.
    logic [`ACSL_EGR_W-1:0]  egress_nxt;  // Next egress vector.

    // Writes reach only the writable fields; reserved bits are dropped.
    always_comb begin
        ena_nxt    = ena_r;
        egress_nxt = egress_r;
        if (wr_in && off_in == `ACSL_OFF_ACS_CAP) begin
            ena_nxt = wdata_in[`ACSL_ENA_MSB:`ACSL_ENA_LSB]; // R9 R13
        end
        if (wr_in && off_in == `ACSL_OFF_EGRESS) begin
            egress_nxt = wdata_in[`ACSL_EGR_W-1:0]; // R10 R13
        end
    end

    // Registers the enables and vector, cleared at reset.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ena_r    <= `ACSL_ENA_RESET; // R9
            egress_r <= `ACSL_EGR_RESET; // R10
        end else begin
            ena_r    <= ena_nxt;
            egress_r <= egress_nxt;
        end
    end

    // Builds read data; constant fields are wired, reserved bits are zero.
    always_comb begin
        rdata_out = 32'h0000_0000;
        hit_out   = 1'b1;
        case (off_in)
            `ACSL_OFF_ACS_HDR: begin
                rdata_out = {`ACSL_NEXT_PTR, `ACSL_CAP_VER, `ACSL_ACS_CAP_ID}; // R3 R4 R5
            end
            `ACSL_OFF_ACS_CAP: begin
                rdata_out = {9'h000, ena_r, `ACSL_EGR_SIZE, 1'b0,
                             `ACSL_FEAT_SUPPORT}; // R7 R8 R13
            end
            `ACSL_OFF_EGRESS: begin
                rdata_out = {24'h00_0000, egress_r}; // R10 R13
            end
            default: begin
                hit_out = 1'b0;
            end
        endcase
    end

    // Enables and vector leave straight from their flops.
    assign ena_out    = ena_r;
    assign egress_out = egress_r;

endmodule

// File: hw/acsl_cap_bank.sv
// Extended-capability register bank of a three-port packet switch.
// Assumes an APB master on the core clock; port 0 is upstream.
//
// Notes on behaviour
// R1: Access control registers exist only downstream.
// R2: Latency registers exist only on upstream.
// R3: Access header id reads fixed 000Dh.
// R4: Access header version reads fixed 1h.
// R5: Both next pointers read fixed 240h.
// R6: Latency header id reads fixed 0018h.
// R7: Feature support bits 0-6 read one.
// R8: Bits 15:8 give egress vector size.
// R9: Bits 16-22 are enables, reset zero.
// R10: Egress vector bits block peer requests.
// R11: Snoop latency value, bits 9:0, read-write.
// R12: Snoop latency scale, bits 12:10, read-write.
// R13: Reserved bits read zero, writes ignored.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "acsl_regs.svh"

module acsl_cap_bank
    import acsl_pkg::*;
(
    input  wire logic                       CLOCK_IN,               // Core clock, 20 MHz.
    input  wire logic                       RESET_N_IN,             // Sync reset, active low.
    input  wire logic                       PSEL_IN,                // APB select.
    input  wire logic                       PENABLE_IN,             // APB access phase.
    input  wire logic                       PWRITE_IN,              // APB direction.
    input  wire logic [`ACSL_ADDR_W-1:0]    PADDR_IN,               // APB byte address.
    input  wire logic [31:0]                PWDATA_IN,              // APB write data.
    output logic      [31:0]                PRDATA_OUT,             // APB read data.
    output logic                            PREADY_OUT,             // APB ready.
    output logic                            PSLVERR_OUT,            // APB error.
    output logic      [`ACSL_FEAT_W-1:0]    DN1_ACS_ENABLE_OUT,     // Port 1 enables.
    output logic      [`ACSL_EGR_W-1:0]     DN1_EGRESS_BLOCK_OUT,   // Port 1 egress vector.
    output logic      [`ACSL_FEAT_W-1:0]    DN2_ACS_ENABLE_OUT,     // Port 2 enables.
    output logic      [`ACSL_EGR_W-1:0]     DN2_EGRESS_BLOCK_OUT,   // Port 2 egress vector.
    output logic      [`ACSL_LAT_VAL_MSB:0] UP_SNOOP_LAT_VALUE_OUT, // Upstream latency value.
    output logic      [2:0]                 UP_SNOOP_LAT_SCALE_OUT  // Upstream latency scale.
);

    // =========================================================
    // Address decode.
    // =========================================================
    logic [1:0]             port_sel;    // Port addressed by the request.
    logic [`ACSL_OFF_MSB:0] off_sel;     // Offset within that port.
    logic                   aligned;     // Word-aligned address.
    logic                   up_hit;      // Upstream register addressed.
    logic [31:0]            up_rdata;    // Upstream read data.
    logic                   req_hit;     // Request lands on a register.
    logic [31:0]            req_rdata;   // Read data of the request.

    // Port number sits above the 4 KiB configuration window.
    assign port_sel = PADDR_IN[`ACSL_PORT_MSB:`ACSL_PORT_LSB];
    assign off_sel  = PADDR_IN[`ACSL_OFF_MSB:0];
    assign aligned  = (PADDR_IN[1:0] == 2'h0);

    // =========================================================
    // APB answer sequencer.
    // =========================================================
    acsl_apb_state_t st_r;        // Current answer state.
    acsl_apb_state_t st_nxt;      // Next answer state.
    logic [31:0]     prdata_r;    // Registered read data.
    logic [31:0]     prdata_nxt;  // Next read data.
    logic            pready_r;    // Registered ready.
    logic            pready_nxt;  // Next ready.
    logic            pslverr_r;   // Registered error.
    logic            pslverr_nxt; // Next error.
    logic            commit;      // Write takes effect this edge.

    // A write lands at the edge where the master sees ready high.
    assign commit = (st_r == ACSL_ANSWER) && PSEL_IN && PENABLE_IN &&
                    PWRITE_IN && req_hit;

    // Access phase is answered one cycle later, then ready drops again.
    always_comb begin
        st_nxt      = st_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        case (st_r)
            ACSL_IDLE: begin
                if (PSEL_IN && PENABLE_IN) begin
                    st_nxt      = ACSL_ANSWER;
                    pready_nxt  = 1'b1;
                    pslverr_nxt = !req_hit;
                    // Writes and unmapped reads return zero data.
                    prdata_nxt  = (!PWRITE_IN && req_hit) ? req_rdata : 32'h0000_0000;
                end
            end
            ACSL_ANSWER: begin
                // Transfer completes this edge; wait for the next access phase.
                st_nxt = ACSL_IDLE;
            end
            default: begin
                st_nxt = ACSL_IDLE;
            end
        endcase
    end

    // Registers the sequencer and bus outputs.
    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            st_r      <= ACSL_IDLE;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign PRDATA_OUT  = prdata_r;
    assign PREADY_OUT  = pready_r;
    assign PSLVERR_OUT = pslverr_r;

    // =========================================================
    // Downstream port register sets.
    // =========================================================
    logic [31:0]             dn_rdata  [2];  // Read data per downstream port.
    logic                    dn_hit    [2];  // Offset hit per downstream port.
    logic [`ACSL_FEAT_W-1:0] dn_ena    [2];  // Enables per downstream port.
    logic [`ACSL_EGR_W-1:0]  dn_egress [2];  // Egress vector per downstream port.

    // One identical set serves each downstream port.
    for (genvar g = 0; g < 2; g++) begin : g_dn
        logic wr_dn; // Commit aimed at this port.

        assign wr_dn = commit && (port_sel == 2'(g + 1)); // R1

        acsl_dn_port_regs u_regs (
            .clk_in     (CLOCK_IN),
            .rst_n_in   (RESET_N_IN),
            .wr_in      (wr_dn),
            .off_in     (off_sel),
            .wdata_in   (PWDATA_IN),
            .rdata_out  (dn_rdata[g]),
            .hit_out    (dn_hit[g]),
            .ena_out    (dn_ena[g]),
            .egress_out (dn_egress[g])
        );
    end

    assign DN1_ACS_ENABLE_OUT   = dn_ena[0];
    assign DN1_EGRESS_BLOCK_OUT = dn_egress[0];
    assign DN2_ACS_ENABLE_OUT   = dn_ena[1];
    assign DN2_EGRESS_BLOCK_OUT = dn_egress[1];

    // =========================================================
    // Upstream latency registers.
    // =========================================================
    logic [`ACSL_LAT_VAL_MSB:0] lat_val_r;   // Snoop latency value.
    logic [`ACSL_LAT_VAL_MSB:0] lat_val_nxt; // Next latency value.
    logic [2:0]                 lat_scl_r;   // Snoop latency scale.
    logic [2:0]                 lat_scl_nxt; // Next latency scale.

    // Only value and scale take write data; bits 15:13 and above are dropped.
    always_comb begin
        lat_val_nxt = lat_val_r;
        lat_scl_nxt = lat_scl_r;
        if (commit && port_sel == `ACSL_PORT_UP && off_sel == `ACSL_OFF_SNOOP) begin // R2
            lat_val_nxt = PWDATA_IN[`ACSL_LAT_VAL_MSB:0]; // R11 R13
            lat_scl_nxt = PWDATA_IN[`ACSL_LAT_SCL_MSB:`ACSL_LAT_SCL_LSB]; // R12 R13
        end
    end

    // Registers the latency fields, cleared at reset.
    always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
            lat_val_r <= `ACSL_LAT_VAL_RESET; // R11
            lat_scl_r <= `ACSL_LAT_SCL_RESET; // R12
        end else begin
            lat_val_r <= lat_val_nxt;
            lat_scl_r <= lat_scl_nxt;
        end
    end

    assign UP_SNOOP_LAT_VALUE_OUT = lat_val_r;
    assign UP_SNOOP_LAT_SCALE_OUT = lat_scl_r;

    // Upstream read mux; only the latency header and register exist.
    always_comb begin
        up_rdata = 32'h0000_0000;
        up_hit   = 1'b1;
        case (off_sel)
            `ACSL_OFF_LTR_HDR: begin
                up_rdata = {`ACSL_NEXT_PTR, `ACSL_CAP_VER, `ACSL_LTR_CAP_ID}; // R5 R6
            end
            `ACSL_OFF_SNOOP: begin
                up_rdata = {19'h0_0000, lat_scl_r, lat_val_r}; // R11 R12 R13
            end
            default: begin
                up_hit = 1'b0;
            end
        endcase
    end

    // =========================================================
    // Port steering of the request.
    // =========================================================
    // Access control offsets on the upstream port, and latency offsets on
    // a downstream port, fall to the unmapped branch.
    always_comb begin
        req_hit   = 1'b0;
        req_rdata = 32'h0000_0000;
        case (port_sel)
            `ACSL_PORT_UP: begin
                req_hit   = up_hit && aligned; // R2
                req_rdata = up_rdata;
            end
            `ACSL_PORT_DN1: begin
                req_hit   = dn_hit[0] && aligned; // R1
                req_rdata = dn_rdata[0];
            end
            `ACSL_PORT_DN2: begin
                req_hit   = dn_hit[1] && aligned; // R1
                req_rdata = dn_rdata[1];
            end
            default: begin
                req_hit = 1'b0;
            end
        endcase
    end

endmodule

// File: bench/acsl_cap_bank_assertions.sv
// Concurrent checks on the APB answers and register outputs of the bank.
// Assumes binding to acsl_cap_bank, one core clock, synchronous reset.
`timescale 1ns/10ps
`include "acsl_regs.svh"

module acsl_cap_bank_chk
    import acsl_pkg::*;
(
    input  wire logic                       CLOCK_IN,               // Core clock.
    input  wire logic                       RESET_N_IN,             // Reset, active low.
    input  wire logic                       PSEL_IN,                // APB select.
    input  wire logic                       PENABLE_IN,             // APB access phase.
    input  wire logic                       PWRITE_IN,              // APB direction.
    input  wire logic [`ACSL_ADDR_W-1:0]    PADDR_IN,               // APB address.
    input  wire logic [31:0]                PWDATA_IN,              // APB write data.
    input  wire logic [31:0]                PRDATA_OUT,             // APB read data.
    input  wire logic                       PREADY_OUT,             // APB ready.
    input  wire logic                       PSLVERR_OUT,            // APB error.
    input  wire logic [`ACSL_FEAT_W-1:0]    DN1_ACS_ENABLE_OUT,     // Port 1 enables.
    input  wire logic [`ACSL_EGR_W-1:0]     DN2_EGRESS_BLOCK_OUT,   // Port 2 egress vector.
    input  wire logic [`ACSL_LAT_VAL_MSB:0] UP_SNOOP_LAT_VALUE_OUT, // Latency value.
    input  wire logic [2:0]                 UP_SNOOP_LAT_SCALE_OUT  // Latency scale.
);
    // =====================================================================
    // Decode helpers shared by the properties.
    // =====================================================================
    wire logic [1:0]  prt    = PADDR_IN[13:12];                        // Port of the transfer.
    wire logic [11:0] off    = PADDR_IN[11:0];                         // Offset of the transfer.
    wire logic        dn     = (prt == 2'h1) || (prt == 2'h2);         // Downstream port.
    wire logic        rd_ok  = PREADY_OUT && !PWRITE_IN && !PSLVERR_OUT; // Accepted read.
    wire logic        wr_ok  = PREADY_OUT && PWRITE_IN && !PSLVERR_OUT;  // Accepted write.
    wire logic [6:0]  wd_ena = PWDATA_IN[22:16];                       // Written enables.
    wire logic [7:0]  wd_egr = PWDATA_IN[7:0];                         // Written vector.
    wire logic [12:0] wd_lat = PWDATA_IN[12:0];                        // Written latency.

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESET_N_IN);

    // =====================================================================
    // Bus timing and register contents.
    // =====================================================================
    AST_ONE_WAIT:
        assert property (PSEL_IN && $rose(PENABLE_IN) |-> !PREADY_OUT ##1 PREADY_OUT)
        else $error("ready did not follow one wait state");
    AST_READY_PULSE:
        assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready held too long");
    AST_ERR_ZERO:
        assert property (PSLVERR_OUT |-> PREADY_OUT && (PRDATA_OUT == 32'h0))
        else $error("error without ready or with data");
    AST_NO_ACS_UP:
        assert property (PREADY_OUT && (prt == 2'h0) && (off >= 12'h220) && (off <= 12'h228)
            |-> PSLVERR_OUT) else $error("access control register seen on upstream");
    AST_NO_LTR_DN:
        assert property (PREADY_OUT && dn && ((off == 12'h230) || (off == 12'h234))
            |-> PSLVERR_OUT) else $error("latency register seen on downstream");
    AST_ACS_HDR:
        assert property (rd_ok && dn && (off == 12'h220) |-> PRDATA_OUT == 32'h2401000d)
        else $error("access control header wrong");
    AST_LTR_HDR:
        assert property (rd_ok && (prt == 2'h0) && (off == 12'h230)
            |-> PRDATA_OUT == 32'h24010018) else $error("latency header wrong");
    AST_CAP_WORD:
        assert property (rd_ok && dn && (off == 12'h224)
            |-> (PRDATA_OUT[15:0] == 16'h087f) && (PRDATA_OUT[31:23] == 9'h000))
        else $error("capability word fixed bits wrong");
    AST_ENA_WRITE:
        assert property (wr_ok && (prt == 2'h1) && (off == 12'h224)
            |=> DN1_ACS_ENABLE_OUT == $past(wd_ena)) else $error("enables not written");
    AST_ENA_HOLD:
        assert property (!(wr_ok && (prt == 2'h1) && (off == 12'h224))
            |=> $stable(DN1_ACS_ENABLE_OUT)) else $error("enables changed without write");
    AST_EGR_WRITE:
        assert property (wr_ok && (prt == 2'h2) && (off == 12'h228)
            |=> DN2_EGRESS_BLOCK_OUT == $past(wd_egr)) else $error("egress not written");
    AST_SNOOP_WRITE:
        assert property (wr_ok && (prt == 2'h0) && (off == 12'h234)
            |=> {UP_SNOOP_LAT_SCALE_OUT, UP_SNOOP_LAT_VALUE_OUT} == $past(wd_lat))
        else $error("snoop latency not written");
endmodule

bind acsl_cap_bank acsl_cap_bank_chk i_chk (.CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .DN1_ACS_ENABLE_OUT(DN1_ACS_ENABLE_OUT),
    .DN2_EGRESS_BLOCK_OUT(DN2_EGRESS_BLOCK_OUT),
    .UP_SNOOP_LAT_VALUE_OUT(UP_SNOOP_LAT_VALUE_OUT),
    .UP_SNOOP_LAT_SCALE_OUT(UP_SNOOP_LAT_SCALE_OUT));

// File: bench/tb_acsl_cap_bank.sv
// Self-checking bench of the capability bank, driven over APB.
// Assumes the bank answers each access after a wait the bench does not fix.
`timescale 1ns/10ps
`include "acsl_regs.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_acsl_cap_bank import acsl_pkg::*; ();
    // =====================================================================
    // Stimulus, design outputs and reference state.
    // =====================================================================
    logic        clk = 1'b0, rst_n = 1'b0;                    // Clock and reset.
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;  // APB control.
    logic [13:0] paddr = 14'h0000;                            // APB address.
    logic [31:0] pwdata = 32'h0, seed = 32'h00000033, rv;     // Data and random state.
    wire logic [31:0] prdata;                                 // Read data seen.
    wire logic        ready, err;                             // Answer flags seen.
    wire logic [6:0]  ena1, ena2;                             // Enables seen.
    wire logic [7:0]  egr1, egr2;                             // Vectors seen.
    wire logic [9:0]  lval;                                   // Latency value seen.
    wire logic [2:0]  lscl;                                   // Latency scale seen.
    int          error_cnt = 0, n_tests = 0, cyc = 0;         // Counters.
    logic [6:0]  ena_m [0:3];                                 // Expected enables.
    logic [7:0]  egr_m [0:3];                                 // Expected vectors.
    logic [9:0]  lval_m;                                      // Expected latency value.
    logic [2:0]  lscl_m;                                      // Expected latency scale.
    logic [11:0] offs [0:6] = '{12'h220, 12'h224, 12'h228, 12'h230, 12'h234, 12'h22c, 12'h226};

    acsl_cap_bank i_dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(ready), .PSLVERR_OUT(err),
        .DN1_ACS_ENABLE_OUT(ena1), .DN1_EGRESS_BLOCK_OUT(egr1), .DN2_ACS_ENABLE_OUT(ena2),
        .DN2_EGRESS_BLOCK_OUT(egr2), .UP_SNOOP_LAT_VALUE_OUT(lval),
        .UP_SNOOP_LAT_SCALE_OUT(lscl));

    // The clock toggles every half period of 25 ns.
    initial begin
        forever #25 clk = ~clk;
    end

    // A hang is cut short after a cycle ceiling well above the test length.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            end_sim();
        end
    end

    // =====================================================================
    // Reference functions and bus tasks.
    // =====================================================================
    // Xorshift step of the repeatable random stream.
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected error flag and read word of one port and offset.
    function automatic logic [32:0] exp_rd(input logic [1:0] p, input logic [11:0] o);
        logic dn;
        dn = (p == 2'h1) || (p == 2'h2);
        case (o)
            12'h220: if (dn) return {1'b0, 32'h2401000d};
            12'h224: if (dn) return {1'b0, 9'h000, ena_m[p], 8'h08, 1'b0, 7'h7f};
            12'h228: if (dn) return {1'b0, 24'h000000, egr_m[p]};
            12'h230: if (p == 2'h0) return {1'b0, 32'h24010018};
            12'h234: if (p == 2'h0) return {1'b0, 19'h00000, lscl_m, lval_m};
            default: ;
        endcase
        return {1'b1, 32'h00000000};
    endfunction

    // One APB transfer; the request is held until ready is seen at an edge.
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (ready !== 1'b1);
        r = prdata;
        e = err;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Compares every register output against the reference state.
    task automatic chk_outs();
        `CHK("port1 enables", ena_m[1], ena1)
        `CHK("port2 enables", ena_m[2], ena2)
        `CHK("port1 egress", egr_m[1], egr1)
        `CHK("port2 egress", egr_m[2], egr2)
        `CHK("snoop value", lval_m, lval)
        `CHK("snoop scale", lscl_m, lscl)
    endtask

    // One checked access; the reference follows only accepted writes.
    task automatic do_op(input logic w, input logic [1:0] p, input logic [11:0] o,
                         input logic [31:0] d);
        logic [32:0] x;
        logic [31:0] r;
        logic        e;
        x = exp_rd(p, o);
        apb(w, {p, o}, d, r, e);
        `CHK("slave error", x[32], e)
        `CHK("read data", w ? 32'h0 : x[31:0], r)
        if (w && !x[32]) begin
            if (o == 12'h224) ena_m[p] = d[22:16];
            if (o == 12'h228) egr_m[p] = d[7:0];
            if (o == 12'h234) {lscl_m, lval_m} = d[12:0];
        end
        @(negedge clk);
        chk_outs();
    endtask

    // Every offset of the table on every port, including unmapped ones.
    task automatic sweep(input logic w, input logic [31:0] d);
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 7; i++) begin
                do_op(w, p[1:0], offs[i], d);
            end
        end
    endtask

    // Holds reset for three cycles and clears the reference state.
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            ena_m[i] = 7'h00;
            egr_m[i] = 8'h00;
        end
        lval_m = 10'h000;
        lscl_m = 3'h0;
        @(negedge clk);
        chk_outs();
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if ((error_cnt == 0) && (n_tests > 0)) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // =====================================================================
    // Main sequence: reset values, all-ones writes, random traffic, reset.
    // =====================================================================
    initial begin
        do_reset();
        sweep(1'b0, 32'h0);
        sweep(1'b1, 32'hffffffff);
        sweep(1'b0, 32'h0);
        repeat (300) begin
            rv = next_rand();
            do_op(rv[0], rv[2:1], offs[rv[5:3] % 7], next_rand());
        end
        sweep(1'b0, 32'h0);
        do_reset();
        sweep(1'b0, 32'h0);
        end_sim();
    end
endmodule
